// ---- rtl/dct_top.sv ----
/*
 Connectivity test mode of a memory device: entry qualification, minterm
 network and mapping onto data and strobe pins with enable control.
 Assumes pins arrive asynchronously; all are synchronised on mclk.
*/
`timescale 1ns/10ps
module dct_top
	import dct_pkg::*;
#(
	parameter dct_pkg::dct_org_t ORG = dct_pkg::DCT_ORG_X16,
	parameter logic [dct_pkg::DCT_NUM_IN-1:0] MINTERM8_MASK = 40'h00_0000_0000
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Mode and qualifying pins
	input wire logic continuity_test_select,
	input wire logic cs_pin_n,
	input wire logic rst_pin_n,
	// Test input pins, packed per dct_pkg positions
	input wire logic [dct_pkg::DCT_NUM_IN-1:0] test_pins,
	// Test output pins
	output logic [15:0] dq_out,
	output logic [15:0] dq_oe,
	output logic [1:0] strobe_t_out,
	output logic [1:0] strobe_c_out,
	output logic [1:0] strobe_oe,
	// Mode indicators
	output logic pin_continuity_mode,
	output logic vref_half_force,
	output logic normal_bypass
);
	import dct_pkg::*;

	localparam int NI = DCT_NUM_IN;
	localparam int NM = DCT_NUM_MT;

	// Fixed input groups; minterm_8 comes from the parameter
	function automatic logic [NI-1:0] bit_of(input int p);
		logic [NI-1:0] v;
		v = '0;
		v[p] = 1'b1;
		return v;
	endfunction

	localparam logic [NI-1:0] M0 = bit_of(1) | bit_of(6) | bit_of(DCT_IN_PAR);
	localparam logic [NI-1:0] M1 = bit_of(8) | bit_of(DCT_IN_ALERT) | bit_of(9);
	localparam logic [NI-1:0] M2 = bit_of(2) | bit_of(5) | bit_of(13) | bit_of(17);
	localparam logic [NI-1:0] M3 = bit_of(0) | bit_of(7) | bit_of(11);
	localparam logic [NI-1:0] M4 = bit_of(DCT_IN_CK_C) | bit_of(DCT_IN_ODT) | bit_of(15);
	localparam logic [NI-1:0] M5 = bit_of(DCT_IN_CKE) | bit_of(16) | bit_of(10);
	localparam logic [NI-1:0] M6 = bit_of(DCT_IN_ACT) | bit_of(4) | bit_of(DCT_IN_BA1);
	localparam logic [NI-1:0] M7 = (ORG == DCT_ORG_X16) ?
		(bit_of(DCT_IN_DMU) | bit_of(DCT_IN_DML) | bit_of(DCT_IN_CK_T)) :
		(ORG == DCT_ORG_X8) ?
		(bit_of(DCT_IN_BG1) | bit_of(DCT_IN_DML) | bit_of(DCT_IN_CK_T)) :
		(bit_of(14) | bit_of(12) | bit_of(DCT_IN_BA0));
	localparam logic [NI-1:0] M9 = bit_of(DCT_IN_BG0) | bit_of(3) | bit_of(DCT_IN_RST_SEL);
	localparam logic [NM*NI-1:0] MT_MASK = {M9, MINTERM8_MASK, M7, M6, M5, M4, M3, M2, M1, M0};

	// Two-flop synchronisers for all pins
	localparam int NS = NI + 3;
	logic [NS-1:0] sync1_reg, sync2_reg;
	logic [NS-1:0] pins_async;
	assign pins_async = {continuity_test_select, cs_pin_n, rst_pin_n, test_pins};

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= pins_async;
			sync2_reg <= sync1_reg;
		end
	end

	logic sel_s, cs_n_s, rst_s;
	logic [NI-1:0] in_s;
	assign sel_s = sync2_reg[NS-1];
	assign cs_n_s = sync2_reg[NS-2];
	assign rst_s = sync2_reg[NS-3];

	// Mode state machine
	typedef enum logic [1:0] {
		DCT_ST_IDLE = 2'h0,
		DCT_ST_SWITCH = 2'h1,
		DCT_ST_SAMPLE = 2'h2,
		DCT_ST_ACTIVE = 2'h3
	} dct_state_t;

	dct_state_t state_reg, state_next;
	logic [DCT_CNT_W-1:0] cnt_reg, cnt_next;
	logic clk_pins_ok, all_pins_ok;

	// Entry needs select high; exit on select low at any time
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			DCT_ST_IDLE: begin
				cnt_next = DCT_CNT_RESET;
				// Entry is only honoured with reset and chip select high
				if (sel_s && rst_s && cs_n_s) begin
					state_next = DCT_ST_SWITCH;
				end
			end
			DCT_ST_SWITCH: begin
				cnt_next = cnt_reg + 8'h01;
				if (cnt_reg == DCT_CNT_W'(DCT_SWITCH_CYC - 1)) begin
					state_next = DCT_ST_SAMPLE;
					// Sampling delay is counted afresh, else it would end at once
					cnt_next = DCT_CNT_RESET;
				end
			end
			DCT_ST_SAMPLE: begin
				if (cnt_reg != DCT_CNT_W'(DCT_SAMPLING_CYC)) begin
					cnt_next = cnt_reg + 8'h01;
				end
				// Remaining inputs accepted after delay when chip select allows
				if (cnt_reg == DCT_CNT_W'(DCT_SAMPLING_CYC) && !cs_n_s) begin
					state_next = DCT_ST_ACTIVE;
				end
			end
			DCT_ST_ACTIVE: begin
				cnt_next = cnt_reg;
			end
			default: begin
				state_next = DCT_ST_IDLE;
				cnt_next = DCT_CNT_RESET;
			end
		endcase
		if (!sel_s) begin
			state_next = DCT_ST_IDLE;
			cnt_next = DCT_CNT_RESET;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= DCT_ST_IDLE;
			cnt_reg <= DCT_CNT_RESET;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	assign clk_pins_ok = (state_reg != DCT_ST_IDLE) && (state_reg != DCT_ST_SWITCH);
	assign all_pins_ok = (state_reg == DCT_ST_ACTIVE);

	// Gate test inputs: clock group after switch delay, rest after sampling delay
	logic [NI-1:0] clk_grp;
	assign clk_grp = bit_of(DCT_IN_CK_C) | bit_of(DCT_IN_CK_T) | bit_of(DCT_IN_CKE);
	always_comb begin
		in_s = sync2_reg[NI-1:0] & ({NI{all_pins_ok}} | (clk_grp & {NI{clk_pins_ok}}));
		in_s[DCT_IN_RST_SEL] = rst_s & sel_s;
	end

	// Minterm network, combinational
	logic [NM-1:0] mt;
	dct_minterm #(
		.NUM_IN(NI),
		.NUM_MT(NM),
		.MT_MASK(MT_MASK)
	) u_minterm (
		.test_in(in_s),
		.minterm(mt)
	);

	// Map minterms onto pins per organisation
	logic [15:0] dq_next;
	logic [1:0] st_t_next, st_c_next;
	logic [15:0] dq_reg;
	logic [1:0] st_t_reg, st_c_reg;
	always_comb begin
		dq_next = 16'h0000;
		case (ORG)
			DCT_ORG_X4: begin
				dq_next[3:0] = {mt[6] ^ mt[7], mt[4] ^ mt[5], mt[2] ^ mt[3], mt[0] ^ mt[1]};
			end
			DCT_ORG_X8: begin
				dq_next[7:0] = mt[7:0];
			end
			DCT_ORG_X16: begin
				dq_next[7:0] = mt[7:0];
				dq_next[15:8] = ~mt[7:0];
			end
			default: begin
				dq_next = 16'h0000;
			end
		endcase
		st_t_next = {(ORG == DCT_ORG_X16) ? ~mt[8] : 1'b0, mt[8]};
		st_c_next = {(ORG == DCT_ORG_X16) ? ~mt[9] : 1'b0, mt[9]};
	end

	// Output register, refreshed every cycle with no pattern shifting
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dq_reg <= 16'h0000;
			st_t_reg <= 2'h0;
			st_c_reg <= 2'h0;
		end else begin
			dq_reg <= dq_next;
			st_t_reg <= st_t_next;
			st_c_reg <= st_c_next;
		end
	end

	// Drive only in active mode with chip select low
	logic drive;
	logic [15:0] dq_used;
	assign drive = all_pins_ok && !cs_n_s;
	assign dq_used = (ORG == DCT_ORG_X4) ? 16'h000F : (ORG == DCT_ORG_X8) ? 16'h00FF : 16'hFFFF;
	assign dq_out = dq_reg;
	assign strobe_t_out = st_t_reg;
	assign strobe_c_out = st_c_reg;
	assign dq_oe = dq_used & {16{drive}};
	assign strobe_oe = {drive && (ORG == DCT_ORG_X16), drive};
	assign pin_continuity_mode = (state_reg != DCT_ST_IDLE);
	assign vref_half_force = pin_continuity_mode;
	assign normal_bypass = pin_continuity_mode;

	// Mode and timing checks
	a_switch_bound: assert property (@(posedge mclk) disable iff (!reset_n)
		(state_reg == DCT_ST_SWITCH) |-> ##[1:8] (state_reg != DCT_ST_SWITCH))
		else $error("switch phase too long");
	a_sample_wait: assert property (@(posedge mclk) disable iff (!reset_n)
		(state_reg == DCT_ST_SAMPLE && cnt_reg != DCT_CNT_W'(DCT_SAMPLING_CYC)) |=>
		(state_reg != DCT_ST_ACTIVE))
		else $error("sampling delay cut short");
	a_enable_cs: assert property (@(posedge mclk) disable iff (!reset_n)
		(cs_n_s || state_reg != DCT_ST_ACTIVE) |-> (dq_oe == 16'h0000))
		else $error("outputs driven while disabled");
	a_exit_select: assert property (@(posedge mclk) disable iff (!reset_n)
		!sel_s |=> (state_reg == DCT_ST_IDLE))
		else $error("mode not left on select low");
	a_entry_guard: assert property (@(posedge mclk) disable iff (!reset_n)
		(state_reg == DCT_ST_IDLE && !(rst_s && cs_n_s)) |=> (state_reg == DCT_ST_IDLE))
		else $error("entry without qualifying pins");
	// Mapping checks
	a_upper_inv: assert property (@(posedge mclk) disable iff (!reset_n)
		(ORG == DCT_ORG_X16) |-> (dq_out[15:8] == ~dq_out[7:0] || !$past(reset_n)))
		else $error("upper byte not inverted");
	a_data_follow: assert property (@(posedge mclk) disable iff (!reset_n)
		(ORG != DCT_ORG_X4) |=> (dq_out[7:0] == $past(mt[7:0])))
		else $error("data does not track minterms");
	a_strobe_c: assert property (@(posedge mclk) disable iff (!reset_n)
		1'b1 |=> (strobe_c_out[0] == $past(mt[9])))
		else $error("complement strobe wrong");
	a_x4_pairs: assert property (@(posedge mclk) disable iff (!reset_n)
		(ORG == DCT_ORG_X4) |=> (dq_out[0] == $past(mt[0] ^ mt[1])))
		else $error("x4 pair XOR wrong");
	a_vref_mode: assert property (@(posedge mclk) disable iff (!reset_n)
		(state_reg == DCT_ST_ACTIVE) |-> (vref_half_force && normal_bypass))
		else $error("reference not forced");
endmodule

// ---- rtl/dct_pkg.sv ----
/*
 Package for the connectivity test block: widths, organisation codes,
 timing figures and cycle counts.
 Assumes a 40 MHz mclk.
*/
package dct_pkg;
	// Data organisation of the device
	typedef enum logic [1:0] {
		DCT_ORG_X4 = 2'h0,
		DCT_ORG_X8 = 2'h1,
		DCT_ORG_X16 = 2'h2
	} dct_org_t;

	// Test input vector width and minterm count
	localparam int DCT_NUM_IN = 40;
	localparam int DCT_NUM_MT = 10;

	// Test input bit positions
	localparam int DCT_IN_A0 = 0; // A0..A17 occupy bits 0..17
	localparam int DCT_IN_BA0 = 18;
	localparam int DCT_IN_BA1 = 19;
	localparam int DCT_IN_BG0 = 20;
	localparam int DCT_IN_BG1 = 21;
	localparam int DCT_IN_PAR = 22;
	localparam int DCT_IN_ALERT = 23;
	localparam int DCT_IN_CK_C = 24;
	localparam int DCT_IN_CK_T = 25;
	localparam int DCT_IN_ODT = 26;
	localparam int DCT_IN_CKE = 27;
	localparam int DCT_IN_ACT = 28;
	localparam int DCT_IN_DML = 29;
	localparam int DCT_IN_DMU = 30;
	localparam int DCT_IN_RST_SEL = 31; // reset_n AND test select

	// Timing figures in ns and derived cycle counts at 40 MHz
	localparam int DCT_CLK_PERIOD_NS = 25;
	localparam int DCT_SWITCH_DELAY_NS = 200;
	localparam int DCT_SAMPLING_DELAY_NS = 200;
	localparam int DCT_SETTLE_TIME_NS = 200;
	localparam int DCT_SWITCH_CYC = (DCT_SWITCH_DELAY_NS + DCT_CLK_PERIOD_NS - 1)
		/ DCT_CLK_PERIOD_NS;
	localparam int DCT_SAMPLING_CYC = (DCT_SAMPLING_DELAY_NS + DCT_CLK_PERIOD_NS - 1)
		/ DCT_CLK_PERIOD_NS;
	localparam int DCT_SETTLE_CYC = DCT_SETTLE_TIME_NS / DCT_CLK_PERIOD_NS;
	localparam int DCT_CNT_W = 8;

	// Reset values
	localparam logic [DCT_NUM_MT-1:0] DCT_MT_RESET = 10'h000;
	localparam logic [DCT_CNT_W-1:0] DCT_CNT_RESET = 8'h00;
endpackage

// ---- rtl/dct_minterm.sv ----
/*
 Minterm network: each minterm is the XOR of the inputs picked by its mask.
 Assumes synchronised inputs from the same clock domain.
*/
`timescale 1ns/10ps
module dct_minterm #(
	parameter int NUM_IN = 40,
	parameter int NUM_MT = 10,
	parameter logic [NUM_MT*NUM_IN-1:0] MT_MASK = '0
) (
	// Test inputs
	input wire logic [NUM_IN-1:0] test_in,
	// Minterm results
	output logic [NUM_MT-1:0] minterm
);
	// One XOR reduction per minterm
	genvar g;
	generate
		for (g = 0; g < NUM_MT; g++) begin : g_mt
			assign minterm[g] = ^(test_in & MT_MASK[g*NUM_IN +: NUM_IN]);
		end
	endgenerate
endmodule

// ---- dv/dct_tester.sv ----
/*
 Board tester model: drives the test select, chip select, device reset
 and packed test input pins of the connectivity test block.
 Assumes the bench calls its tasks and mclk paces every pin change.
*/
`timescale 1ns/10ps
module dct_tester
	import dct_pkg::*;
(
	// Clock used to pace pin changes
	input wire logic mclk,
	// Pins driven towards the device
	output logic continuity_test_select,
	output logic cs_pin_n,
	output logic rst_pin_n,
	output logic [dct_pkg::DCT_NUM_IN-1:0] test_pins
);
	// Pins start idle: select low, chip select and device reset high
	initial begin
		continuity_test_select = 1'b0;
		cs_pin_n = 1'b1;
		rst_pin_n = 1'b1;
		test_pins = '0;
	end

	// Raise select only after power-up, reset and chip select held high
	task enter;
		@(negedge mclk);
		rst_pin_n = 1'b1;
		cs_pin_n = 1'b1;
		@(negedge mclk);
		continuity_test_select = 1'b1;
	endtask

	// Change chip select
	task chip(input logic v);
		@(negedge mclk);
		cs_pin_n = v;
	endtask

	// Apply a new test pattern; no refresh is ever issued meanwhile
	task drive(input logic [DCT_NUM_IN-1:0] p);
		@(negedge mclk);
		test_pins = p;
	endtask

	// Drop select, invert the test inputs and hold device reset low for 4 cycles
	task leave;
		@(negedge mclk);
		continuity_test_select = 1'b0;
		test_pins = ~test_pins;
		rst_pin_n = 1'b0;
		repeat (4) @(negedge mclk);
		rst_pin_n = 1'b1;
	endtask
endmodule

// ---- dv/dct_top_test.sv ----
/*
 Self-checking bench for the connectivity test block in x16, x8 and x4 form.
 Assumes the tester model drives the pins and outputs settle in 8 cycles.
*/
`timescale 1ns/10ps
module dct_top_test;
	import dct_pkg::*;
	typedef struct packed {
		logic [15:0] dq;
		logic [15:0] oe;
		logic [1:0] st;
		logic [1:0] sc;
		logic [1:0] so;
		logic md;
		logic [7:0] dq8;
		logic [3:0] dq4;
	} dct_exp_t;
	localparam logic [39:0] MINTERM8_MASK = 40'h00_0000_5000;
	logic mclk, reset_n, look, sel, cs_n, rst_n, vref, byp, mode;
	logic [39:0] pins, p;
	logic [15:0] dq_out, dq_oe, dq8_out, dq8_oe, dq4_out, dq4_oe;
	logic [1:0] st, sc, so, st8, sc8, so8, st4, sc4, so4;
	int failures, samples_checked, seed;
	dct_exp_t exp_q[$];

	dct_tester u_dct_tester (.mclk(mclk), .continuity_test_select(sel), .cs_pin_n(cs_n),
		.rst_pin_n(rst_n), .test_pins(pins));
	dct_top #(.ORG(DCT_ORG_X16), .MINTERM8_MASK(MINTERM8_MASK)) u_dct_top (.mclk(mclk),
		.reset_n(reset_n), .continuity_test_select(sel), .cs_pin_n(cs_n), .rst_pin_n(rst_n),
		.test_pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .strobe_t_out(st),
		.strobe_c_out(sc), .strobe_oe(so), .pin_continuity_mode(mode),
		.vref_half_force(vref), .normal_bypass(byp));
	// Narrower organisations see the same pins
	dct_top #(.ORG(DCT_ORG_X8), .MINTERM8_MASK(MINTERM8_MASK)) u_dct_top_x8 (.mclk(mclk),
		.reset_n(reset_n), .continuity_test_select(sel), .cs_pin_n(cs_n), .rst_pin_n(rst_n),
		.test_pins(pins), .dq_out(dq8_out), .dq_oe(dq8_oe), .strobe_t_out(st8),
		.strobe_c_out(sc8), .strobe_oe(so8), .pin_continuity_mode(),
		.vref_half_force(), .normal_bypass());
	dct_top #(.ORG(DCT_ORG_X4), .MINTERM8_MASK(MINTERM8_MASK)) u_dct_top_x4 (.mclk(mclk),
		.reset_n(reset_n), .continuity_test_select(sel), .cs_pin_n(cs_n), .rst_pin_n(rst_n),
		.test_pins(pins), .dq_out(dq4_out), .dq_oe(dq4_oe), .strobe_t_out(st4),
		.strobe_c_out(sc4), .strobe_oe(so4), .pin_continuity_mode(),
		.vref_half_force(), .normal_bypass());

	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Expected pins from the minterm groups and the x16 mapping
	function automatic dct_exp_t exp_of(input logic [39:0] v, input logic on, input logic md);
		logic [9:0] m;
		logic [7:0] x;
		dct_exp_t e;
		m[0] = v[1] ^ v[6] ^ v[22];
		m[1] = v[8] ^ v[23] ^ v[9];
		m[2] = v[2] ^ v[5] ^ v[13] ^ v[17];
		m[3] = v[0] ^ v[7] ^ v[11];
		m[4] = v[24] ^ v[26] ^ v[15];
		m[5] = v[27] ^ v[16] ^ v[10];
		m[6] = v[28] ^ v[4] ^ v[19];
		m[7] = v[30] ^ v[29] ^ v[25];
		m[8] = ^(v & MINTERM8_MASK);
		m[9] = v[20] ^ v[3] ^ 1'b1;
		e.dq = {~m[7:0], m[7:0]};
		e.st = {~m[8], m[8]};
		e.sc = {~m[9], m[9]};
		e.oe = {16{on}};
		e.so = {2{on}};
		e.md = md;
		// x8 minterm_7 uses BG1, DM lower, CK_t; x4 uses A14, A12, BA0
		e.dq8 = {v[21] ^ v[29] ^ v[25], m[6:0]};
		x = {v[14] ^ v[12] ^ v[18], m[6:0]};
		e.dq4 = {x[6] ^ x[7], x[4] ^ x[5], x[2] ^ x[3], x[0] ^ x[1]};
		return e;
	endfunction

	// Compare one value and count it
	task check(input string name, input logic [39:0] seen, input logic [39:0] want);
		samples_checked++;
		if (seen !== want) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, want, seen);
		end
	endtask

	// Note an expectation, let the settle time pass, then flag the monitor
	task note(input dct_exp_t e);
		exp_q.push_back(e);
		repeat (DCT_SETTLE_CYC) @(negedge mclk);
		look = 1'b1;
		@(negedge mclk);
		look = 1'b0;
	endtask

	// Monitor: oldest note against the settled outputs
	always @(posedge mclk) begin : watch
		dct_exp_t e;
		if (look) begin
			e = exp_q.pop_front();
			check("dq_oe", 40'(dq_oe), 40'(e.oe));
			check("strobe_oe", 40'(so), 40'(e.so));
			check("mode", 40'(mode), 40'(e.md));
			check("vref", 40'(vref), 40'(e.md));
			check("bypass", 40'(byp), 40'(e.md));
			check("x8 dq_oe", 40'(dq8_oe), 40'({8'h00, {8{e.so[0]}}}));
			check("x4 dq_oe", 40'(dq4_oe), 40'({12'h000, {4{e.so[0]}}}));
			check("narrow strobe_oe", 40'({so8, so4}), 40'({1'b0, e.so[0], 1'b0, e.so[0]}));
			if (e.oe[0]) begin
				check("x8 dq_out", 40'(dq8_out), 40'({8'h00, e.dq8}));
				check("x4 dq_out", 40'(dq4_out), 40'({12'h000, e.dq4}));
				check("x8 strobes", 40'({st8, sc8}), 40'({1'b0, e.st[0], 1'b0, e.sc[0]}));
				check("x4 strobes", 40'({st4, sc4}), 40'({1'b0, e.st[0], 1'b0, e.sc[0]}));
			end
			if (e.oe[0]) begin
				check("dq_out", 40'(dq_out), 40'(e.dq));
				check("strobe_t", 40'(st), 40'(e.st));
				check("strobe_c", 40'(sc), 40'(e.sc));
			end
		end
	end

	// Count summary and verdict
	task results;
		$display("checked %0d, failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Watchdog well past the expected run length
	initial begin
		repeat (4000) @(posedge mclk);
		failures++;
		results;
	end

	// Main sequence
	initial begin
		failures = 0;
		samples_checked = 0;
		look = 1'b0;
		seed = 56;
		reset_n = 1'b0;
		p = '0;
		repeat (4) @(negedge mclk);
		reset_n = 1'b1;
		note(exp_of(p, 1'b0, 1'b0));
		$display("test idle done");
		// Entry with chip select still high keeps the outputs released
		u_dct_tester.enter();
		note(exp_of(p, 1'b0, 1'b1));
		repeat (12) @(negedge mclk);
		u_dct_tester.chip(1'b0);
		$display("test entry done");
		// Boundary patterns first, then random ones
		for (int i = 0; i < 24; i++) begin
			p = (i == 0) ? 40'h00_0000_0000 : (i == 1) ? 40'hFF_FFFF_FFFF :
				40'({$random(seed), $random(seed)});
			u_dct_tester.drive(p);
			note(exp_of(p, 1'b1, 1'b1));
		end
		$display("test patterns done");
		u_dct_tester.chip(1'b1);
		note(exp_of(p, 1'b0, 1'b1));
		u_dct_tester.chip(1'b0);
		note(exp_of(p, 1'b1, 1'b1));
		$display("test chip select done");
		u_dct_tester.leave();
		note(exp_of(p, 1'b0, 1'b0));
		$display("test exit done");
		// Reset in mid-run while active
		u_dct_tester.enter();
		repeat (14) @(negedge mclk);
		u_dct_tester.chip(1'b0);
		p = 40'({$random(seed), $random(seed)});
		u_dct_tester.drive(p);
		note(exp_of(p, 1'b1, 1'b1));
		reset_n = 1'b0;
		note(exp_of(p, 1'b0, 1'b0));
		u_dct_tester.leave();
		reset_n = 1'b1;
		note(exp_of(p, 1'b0, 1'b0));
		$display("test reset done");
		results;
	end
endmodule
